// *** atf_fifo.v ***
// Sector data FIFO with registered full and empty flags
`timescale 1ns/1ps
module atf_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clk_sys_i,
   input wire rst_i,
   input wire [WIDTH-1:0] in_data_i,
   input wire in_valid_i,
   output reg in_ready_o,
   output wire [WIDTH-1:0] out_data_o,
   output reg out_valid_o,
   input wire out_ready_i
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire push;
   wire pop;
   reg [AW:0] next_count;

   assign push = in_valid_i & in_ready_o;
   assign pop = out_ready_i & out_valid_o;
   assign out_data_o = mem[rd_ptr];

   // Occupancy after this cycle
   always @* begin
      next_count = count;
      if (push & ~pop) begin
         next_count = count + 1'b1;
      end else if (pop & ~push) begin
         next_count = count - 1'b1;
      end
   end

   // Storage write
   always @(posedge clk_sys_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // Pointers and flags
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
         in_ready_o <= 1'b1;
         out_valid_o <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         count <= next_count;
         in_ready_o <= (next_count != DEPTH[AW:0]);
         out_valid_o <= (next_count != {(AW+1){1'b0}});
      end
   end
endmodule

// *** atf_host_model.sv ***
// Host adapter model running programmed I/O cycles on the task-file pins
`timescale 1ns/1ps
module atf_host_model (
   input wire clk_sys_i,
   output reg cmd_sel_n_o,
   output reg ctl_sel_n_o,
   output reg [2:0] addr_o,
   output reg [1:0] en_n_o,
   output reg rd_n_o,
   output reg wr_n_o,
   output reg [15:0] data_o,
   input wire [15:0] data_i,
   input wire [15:0] oe_i
);
   // Idle bus at time zero
   initial begin
      {cmd_sel_n_o, ctl_sel_n_o, rd_n_o, wr_n_o, en_n_o} = 6'h3F;
      addr_o = 3'h0;
      data_o = 16'h5A5A;
   end
   // One cycle: only one block select at a time is decoded
   task cyc(input ctl, input [2:0] a, input [1:0] en, input wr, input [15:0] d,
      output [15:0] q, output [15:0] oe);
      begin
         @(negedge clk_sys_i);
         cmd_sel_n_o = ctl;
         ctl_sel_n_o = !ctl;
         addr_o = a;
         en_n_o = en;
         data_o = d;
         @(negedge clk_sys_i);
         if (wr) rd_n_o = 1'b1;
         else rd_n_o = 1'b0;
         wr_n_o = !wr;
         repeat (4) @(negedge clk_sys_i);
         q = data_i; // Readback is handed on, never acted upon
         oe = oe_i;
         rd_n_o = 1'b1;
         wr_n_o = 1'b1;
         repeat (4) @(negedge clk_sys_i);
         cmd_sel_n_o = 1'b1;
         ctl_sel_n_o = 1'b1;
         data_o = ~data_o; // Released bus no longer shows the word
      end
   endtask
endmodule

// *** atf_regs.vh ***
// Offsets, bit positions, reset values and sizes of the task-file bank
`ifndef ATF_REGS_VH
`define ATF_REGS_VH
// Command block offsets, selected by the command select
`define ATF_OFF_DATA 3'h0
`define ATF_OFF_ERR_FEAT 3'h1
`define ATF_OFF_SECCNT 3'h2
`define ATF_OFF_SECNUM 3'h3
`define ATF_OFF_CYL_LO 3'h4
`define ATF_OFF_CYL_HI 3'h5
`define ATF_OFF_DRVHEAD 3'h6
// Control block offset of the drive address readback
`define ATF_OFF_DRVADDR 3'h7
// Drive/head register fields
`define ATF_DH_LBA 6
`define ATF_DH_DRV 4
`define ATF_DH_HEAD_HI 3
`define ATF_DH_HEAD_LO 0
// Drive address readback fields
`define ATF_DA_RSVD 7
`define ATF_DA_WRITE_N 6
`define ATF_DA_HEAD_HI 5
`define ATF_DA_HEAD_LO 2
`define ATF_DA_DRV1_N 1
`define ATF_DA_DRV0_N 0
// Reset values
`define ATF_RST_BYTE 8'h00
`define ATF_RST_WORD 16'h0000
`define ATF_RST_DRVHEAD 8'hA0
`define ATF_RST_SECCNT 8'h01
// Sector count of zero stands for this many sectors
`define ATF_FULL_SECCNT 9'h100
// Output enables for no lane, one byte lane or both lanes, and for the readback lanes
`define ATF_OE_NONE 16'h0000
`define ATF_OE_LO 16'h00FF
`define ATF_OE_HI 16'hFF00
`define ATF_OE_WORD 16'hFFFF
`define ATF_OE_DRVADDR 16'h007F
// Positions of the pins in the synchroniser bundle and its idle value
`define ATF_PIN_CMD_SEL 24
`define ATF_PIN_CTL_SEL 23
`define ATF_PIN_ADDR_HI 22
`define ATF_PIN_ADDR_LO 20
`define ATF_PIN_LO_EN 19
`define ATF_PIN_HI_EN 18
`define ATF_PIN_RD 17
`define ATF_PIN_WR 16
`define ATF_PIN_DATA_HI 15
`define ATF_PIN_IDLE 25'h18F_0000
// Synchroniser and buffer sizes
`define ATF_SYNC_W 25
`define ATF_FIFO_DEPTH 16
`define ATF_FIFO_AW 4
`define ATF_WORD_W 16
`endif

// *** atf_sync2.v ***
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module atf_sync2 #(
   parameter WIDTH = 8,
   parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
   input wire clk_sys_i,
   input wire rst_i,
   input wire [WIDTH-1:0] async_i,
   output reg [WIDTH-1:0] sync_o
);
   reg [WIDTH-1:0] meta;

   // First stage is read only by the second stage
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         meta <= RESET_VAL;
         sync_o <= RESET_VAL;
      end else begin
         meta <= async_i;
         sync_o <= meta;
      end
   end
endmodule

// *** atf_task_file.v ***
// Task-file register bank with data port, address registers and drive address readback
`timescale 1ns/1ps
`include "atf_regs.vh"
// What this block does
// RQ1: Readback bit 6 is low while a media write is in progress.
// RQ2: Readback bits 5..2 are inverted head select bits 3..0.
// RQ3: Readback bit 1 is low when drive 1 is active and selected.
// RQ4: Readback bit 0 is low when drive 0 is active and selected.
// RQ5: Sixteen-bit data port moves sector buffer words to and from host.
// RQ6: Offset zero is data, error on reads, feature on writes by enables.
// RQ7: Offset zero write, high enable only, loads feature from D15-D8.
// RQ8: Sector count zero requests 256 sectors.
// RQ9: Successful command completion leaves sector count at zero.
// RQ10: Failed command leaves remaining sector count in the register.
// RQ11: Sector number holds start sector or address bits 7-0.
// RQ12: Cylinder low holds cylinder low byte or address bits 15-8.
// RQ13: Cylinder high holds cylinder high byte or address bits 23-16.
// RQ14: Optional mode ignores accesses at the drive address location.
// RQ15: Host adapter should decode only command and control block addresses.
// RQ16: Host must not rely on readback when that location is undecoded.
// RQ17: Logical address bits 27-24 come from the head select bits.
// RQ18: Readback bit 7 is reserved and never driven.
// RQ19: Sector count decrements once per fully transferred sector.
module atf_task_file #(
   parameter FIFO_DEPTH = `ATF_FIFO_DEPTH,
   parameter FIFO_AW = `ATF_FIFO_AW,
   parameter WORD_W = `ATF_WORD_W
) (
   input wire clk_sys_i,
   input wire rst_i,
   // Host pins
   input wire cmd_sel_n_i,
   input wire ctl_sel_n_i,
   input wire [2:0] addr_i,
   input wire low_byte_card_enable_n_i,
   input wire high_byte_card_enable_n_i,
   input wire rd_n_i,
   input wire wr_n_i,
   input wire [15:0] data_i,
   output reg [15:0] data_o,
   output reg [15:0] data_oe_o,

   // Configuration
   input wire drive_id_i,
   input wire ignore_drive_addr_i,

   // Media engine status
   input wire write_busy_i,
   input wire [7:0] error_bits_i,
   input wire sector_done_i,
   input wire cmd_done_i,
   input wire cmd_ok_i,

   // Media read data into the sector buffer
   input wire [WORD_W-1:0] media_rd_data_i,
   input wire media_rd_valid_i,
   output wire media_rd_ready_o,

   // Host write data toward the media
   output reg [WORD_W-1:0] media_wr_data_o,
   output reg media_wr_valid_o,
   input wire media_wr_ready_i,

   // Task-file contents toward the engine
   output reg [7:0] feature_select_o,
   output reg [7:0] transfer_sector_count_o,
   output reg [8:0] sectors_requested_o,
   output reg [27:0] logical_block_address_o,
   output reg [3:0] head_select_bits_o,
   output reg lba_mode_o,
   output reg drive_bit_o
);

   // Synchronised pins
   wire [`ATF_SYNC_W-1:0] pins_s;
   wire cmd_sel_s;
   wire ctl_sel_s;
   wire [2:0] addr_s;
   wire lo_en_s;
   wire hi_en_s;
   wire rd_s;
   wire wr_s;
   wire [15:0] wdata_s;

   // Strobe history and edges
   reg rd_d;
   reg wr_d;
   wire rd_fall;
   wire rd_rise;
   wire wr_rise;

   // Register bank
   reg [7:0] start_sector_number;
   reg [7:0] cylinder_low_byte;
   reg [7:0] cylinder_high_byte;
   reg [7:0] drive_head;
   reg [7:0] next_seccnt;

   // Access decode
   wire cmd_hit;
   wire da_hit;
   wire dev_selected;
   wire [7:0] drive_address_readback;
   wire [3:0] head_bits;
   reg rd_is_data;

   // Host access strobes
   wire host_wr;
   wire seccnt_wr;
   wire media_word_wr;
   wire host_rd;
   wire da_rd;

   // Sector buffer read side
   wire [WORD_W-1:0] fifo_data;
   wire fifo_valid;
   wire fifo_pop;

   atf_sync2 #(
      .WIDTH(`ATF_SYNC_W),
      .RESET_VAL(`ATF_PIN_IDLE)
   ) u_sync (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .async_i({cmd_sel_n_i, ctl_sel_n_i, addr_i, low_byte_card_enable_n_i,
                high_byte_card_enable_n_i, rd_n_i, wr_n_i, data_i}),
      .sync_o(pins_s)
   );

   // Unpack synchronised pins, turning selects, enables and strobes active-high
   assign cmd_sel_s = ~pins_s[`ATF_PIN_CMD_SEL];
   assign ctl_sel_s = ~pins_s[`ATF_PIN_CTL_SEL];
   assign addr_s = pins_s[`ATF_PIN_ADDR_HI:`ATF_PIN_ADDR_LO];
   assign lo_en_s = ~pins_s[`ATF_PIN_LO_EN];
   assign hi_en_s = ~pins_s[`ATF_PIN_HI_EN];
   assign rd_s = ~pins_s[`ATF_PIN_RD];
   assign wr_s = ~pins_s[`ATF_PIN_WR];
   assign wdata_s = pins_s[`ATF_PIN_DATA_HI:0];

   // Strobe edge history
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         rd_d <= 1'b0;
         wr_d <= 1'b0;
      end else begin
         rd_d <= rd_s;
         wr_d <= wr_s;
      end
   end

   assign rd_fall = rd_s & ~rd_d;
   assign rd_rise = ~rd_s & rd_d;
   assign wr_rise = ~wr_s & wr_d;

   // Command block and drive address decode
   assign cmd_hit = cmd_sel_s & ~ctl_sel_s;
   assign da_hit = ctl_sel_s & ~cmd_sel_s & (addr_s == `ATF_OFF_DRVADDR)
                   & ~ignore_drive_addr_i; // RQ14
   assign dev_selected = (drive_head[`ATF_DH_DRV] == drive_id_i);
   assign head_bits = drive_head[`ATF_DH_HEAD_HI:`ATF_DH_HEAD_LO];

   // Strobes for each kind of host access, taken on synchronised edges
   assign host_wr = wr_rise & cmd_hit;
   assign seccnt_wr = host_wr & (addr_s == `ATF_OFF_SECCNT) & lo_en_s;
   assign media_word_wr = host_wr & (addr_s == `ATF_OFF_DATA) & lo_en_s;
   assign host_rd = rd_fall & cmd_hit;
   assign da_rd = rd_fall & da_hit;

   // Drive address readback, bit 7 left reserved
   assign drive_address_readback[`ATF_DA_RSVD] = 1'b0; // RQ18
   assign drive_address_readback[`ATF_DA_WRITE_N] = ~write_busy_i; // RQ1
   assign drive_address_readback[`ATF_DA_HEAD_HI:`ATF_DA_HEAD_LO] =
      ~head_bits; // RQ2
   assign drive_address_readback[`ATF_DA_DRV1_N] =
      ~(dev_selected & drive_id_i); // RQ3
   assign drive_address_readback[`ATF_DA_DRV0_N] =
      ~(dev_selected & ~drive_id_i); // RQ4

   // Sector count: host load, per-sector decrement, completion clear
   always @* begin
      next_seccnt = transfer_sector_count_o;
      if (cmd_done_i & cmd_ok_i) begin
         next_seccnt = `ATF_RST_BYTE; // RQ9
      end else if (sector_done_i) begin
         next_seccnt = transfer_sector_count_o - 8'h01; // RQ19
      end else if (seccnt_wr) begin
         next_seccnt = wdata_s[7:0];
      end
      // A failed completion keeps the remaining count as it stands
      // RQ10
   end

   // Host writes into the address and feature registers
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         feature_select_o <= `ATF_RST_BYTE;
         transfer_sector_count_o <= `ATF_RST_SECCNT;
         start_sector_number <= `ATF_RST_SECCNT;
         cylinder_low_byte <= `ATF_RST_BYTE;
         cylinder_high_byte <= `ATF_RST_BYTE;
         drive_head <= `ATF_RST_DRVHEAD;
      end else begin
         transfer_sector_count_o <= next_seccnt;
         if (host_wr) begin
            case (addr_s)
               `ATF_OFF_DATA: begin
                  if (hi_en_s & ~lo_en_s) begin
                     feature_select_o <= wdata_s[15:8]; // RQ7
                  end
               end
               `ATF_OFF_ERR_FEAT: begin
                  if (lo_en_s) begin
                     feature_select_o <= wdata_s[7:0]; // RQ6
                  end
               end
               `ATF_OFF_SECNUM: begin
                  if (lo_en_s) begin
                     start_sector_number <= wdata_s[7:0]; // RQ11
                  end
               end
               `ATF_OFF_CYL_LO: begin
                  if (lo_en_s) begin
                     cylinder_low_byte <= wdata_s[7:0]; // RQ12
                  end
               end
               `ATF_OFF_CYL_HI: begin
                  if (lo_en_s) begin
                     cylinder_high_byte <= wdata_s[7:0]; // RQ13
                  end
               end
               `ATF_OFF_DRVHEAD: begin
                  if (lo_en_s) begin
                     drive_head <= wdata_s[7:0];
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   // Registered views of the bank for the media engine
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         sectors_requested_o <= {1'b0, `ATF_RST_SECCNT};
         logical_block_address_o <= 28'h000_0000;
         head_select_bits_o <= 4'h0;
         lba_mode_o <= 1'b0;
         drive_bit_o <= 1'b0;
      end else begin
         sectors_requested_o <= (next_seccnt == `ATF_RST_BYTE) ? `ATF_FULL_SECCNT
                                : {1'b0, next_seccnt}; // RQ8
         logical_block_address_o <= {head_bits,
                                     cylinder_high_byte, cylinder_low_byte,
                                     start_sector_number}; // RQ17
         head_select_bits_o <= head_bits;
         lba_mode_o <= drive_head[`ATF_DH_LBA];
         drive_bit_o <= drive_head[`ATF_DH_DRV];
      end
   end

   // Host write data toward the media, held until taken
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         media_wr_data_o <= `ATF_RST_WORD;
         media_wr_valid_o <= 1'b0;
      end else begin
         if (media_word_wr) begin
            media_wr_data_o <= hi_en_s ? wdata_s : {8'h00, wdata_s[7:0]}; // RQ5
            media_wr_valid_o <= 1'b1;
         end else if (media_wr_ready_i) begin
            media_wr_valid_o <= 1'b0;
         end
      end
   end

   // Sector buffer between media reads and the host data port
   atf_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_fifo (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .in_data_i(media_rd_data_i),
      .in_valid_i(media_rd_valid_i),
      .in_ready_o(media_rd_ready_o),
      .out_data_o(fifo_data),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_pop)
   );

   // A data word leaves the buffer when the host ends its read
   assign fifo_pop = rd_rise & rd_is_data & fifo_valid; // RQ5

   // Read path: drive data at the strobe start, release at its end
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         data_o <= `ATF_RST_WORD;
         data_oe_o <= `ATF_OE_NONE;
         rd_is_data <= 1'b0;
      end else if (da_rd) begin
         data_o <= {8'h00, drive_address_readback};
         data_oe_o <= `ATF_OE_DRVADDR; // RQ18
      end else if (host_rd) begin
         data_oe_o <= `ATF_OE_LO;
         rd_is_data <= 1'b0;
         case (addr_s)
            `ATF_OFF_DATA: begin
               if (hi_en_s & ~lo_en_s) begin
                  data_o <= {error_bits_i, 8'h00}; // RQ6
                  data_oe_o <= `ATF_OE_HI;
               end else begin
                  data_o <= fifo_valid ? fifo_data : `ATF_RST_WORD;
                  data_oe_o <= hi_en_s ? `ATF_OE_WORD : `ATF_OE_LO;
                  rd_is_data <= lo_en_s;
               end
            end
            `ATF_OFF_ERR_FEAT: begin
               data_o <= {8'h00, error_bits_i}; // RQ6
            end
            `ATF_OFF_SECCNT: begin
               data_o <= {8'h00, transfer_sector_count_o};
            end
            `ATF_OFF_SECNUM: begin
               data_o <= {8'h00, start_sector_number}; // RQ11
            end
            `ATF_OFF_CYL_LO: begin
               data_o <= {8'h00, cylinder_low_byte}; // RQ12
            end
            `ATF_OFF_CYL_HI: begin
               data_o <= {8'h00, cylinder_high_byte}; // RQ13
            end
            `ATF_OFF_DRVHEAD: begin
               data_o <= {8'h00, drive_head};
            end
            default: begin
               data_o <= `ATF_RST_WORD;
               data_oe_o <= `ATF_OE_NONE;
            end
         endcase
      end else if (rd_rise) begin
         data_oe_o <= `ATF_OE_NONE;
         rd_is_data <= 1'b0;
      end
   end
endmodule

// *** atf_task_file_bench.sv ***
// Self-checking bench of the task-file register bank
`timescale 1ns/1ps
module atf_task_file_bench;
   reg clk_sys_i, rst_i, drive_id, ignore, busy, sdone, cdone, cok, mr_valid, mw_ready;
   reg [7:0] err_bits, dh;
   reg [15:0] mr_data, q, oe, d;
   reg [7:0] v [0:3];
   reg [15:0] w [0:15];
   wire cs_n, cc_n, rd_n, wr_n, mr_ready, mw_valid, lba_m, drv;
   wire [1:0] en_n;
   wire [2:0] addr;
   wire [15:0] hdata, data_o, data_oe_o, mw_data;
   wire [7:0] feat, cnt;
   wire [8:0] sreq;
   wire [27:0] logical_block_address;
   wire [3:0] head;
   integer err_total, tests_run, i, k, seed;
   atf_task_file uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cmd_sel_n_i(cs_n),
      .ctl_sel_n_i(cc_n), .addr_i(addr), .low_byte_card_enable_n_i(en_n[0]),
      .high_byte_card_enable_n_i(en_n[1]), .rd_n_i(rd_n), .wr_n_i(wr_n), .data_i(hdata),
      .data_o(data_o), .data_oe_o(data_oe_o), .drive_id_i(drive_id),
      .ignore_drive_addr_i(ignore), .write_busy_i(busy), .error_bits_i(err_bits),
      .sector_done_i(sdone), .cmd_done_i(cdone), .cmd_ok_i(cok), .media_rd_data_i(mr_data),
      .media_rd_valid_i(mr_valid), .media_rd_ready_o(mr_ready), .media_wr_data_o(mw_data),
      .media_wr_valid_o(mw_valid), .media_wr_ready_i(mw_ready), .feature_select_o(feat),
      .transfer_sector_count_o(cnt), .sectors_requested_o(sreq),
      .logical_block_address_o(logical_block_address), .head_select_bits_o(head), .lba_mode_o(lba_m),
      .drive_bit_o(drv));
   atf_host_model host (.clk_sys_i(clk_sys_i), .cmd_sel_n_o(cs_n), .ctl_sel_n_o(cc_n),
      .addr_o(addr), .en_n_o(en_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .data_o(hdata),
      .data_i(data_o), .oe_i(data_oe_o));
   // 50 MHz clock
   initial begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   task chk(input [31:0] got, input [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task rd(input c, input [2:0] a, input [1:0] en);
      host.cyc(c, a, en, 1'b0, 16'h0000, q, oe);
   endtask
   task wr(input c, input [2:0] a, input [1:0] en, input [15:0] x);
      host.cyc(c, a, en, 1'b1, x, q, oe);
   endtask
   // Engine pulse, then one settled cycle
   task eng(input s, input c, input ok);
      begin
         @(negedge clk_sys_i);
         {sdone, cdone, cok} = {s, c, ok};
         @(negedge clk_sys_i);
         {sdone, cdone} = 2'b00;
         @(negedge clk_sys_i);
      end
   endtask
   // Host data write with the media side stalling first
   task mw(input [1:0] en, input [15:0] x, input [15:0] e);
      begin
         mw_ready = 1'b0;
         wr(1'b0, 3'h0, en, x);
         repeat (2) @(negedge clk_sys_i);
         chk({mw_valid, mw_data}, {1'b1, e});
         mw_ready = 1'b1;
         repeat (2) @(negedge clk_sys_i);
         chk(mw_valid, 1'b0);
      end
   endtask
   function [15:0] da(input [7:0] h, input id, input b);
      da = {9'h000, !b, ~h[3:0], !(h[4] & id), h[4] | id};
   endfunction
   task finish_test;
      begin
         $display("Comparisons %0d mismatches %0d", tests_run, err_total);
         if (err_total == 0 && tests_run > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   // Watchdog
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      err_total = err_total + 1;
      finish_test;
   end
   // Main sequence
   initial begin
      seed = 32'ha769;
      {err_total, tests_run} = 0;
      {rst_i, drive_id, ignore, busy, sdone, cdone, cok, mr_valid, mw_ready} = 9'h100;
      {err_bits, mr_data} = 24'h00_0000;
      repeat (20) @(negedge clk_sys_i);
      rst_i = 1'b0;
      for (i = 2; i < 6; i = i + 1) begin
         rd(1'b0, i[2:0], 2'b10);
         chk({q[7:0], oe}, {(i < 4) ? 8'h01 : 8'h00, 16'h00FF});
      end
      for (i = 0; i < 8; i = i + 1) begin
         for (k = 0; k < 4; k = k + 1) v[k] = (i == 0) ? 8'h00 : $random(seed);
         dh = (i == 1) ? 8'hEF : ($random(seed) | 8'hA0);
         {busy, drive_id} = $random(seed);
         for (k = 2; k < 6; k = k + 1) wr(1'b0, k[2:0], 2'b10, {~v[k-2], v[k-2]});
         wr(1'b0, 3'h6, 2'b10, {8'h00, dh});
         chk(sreq, (v[0] == 8'h00) ? 9'h100 : {1'b0, v[0]});
         chk(logical_block_address, {dh[3:0], v[3], v[2], v[1]});
         chk({lba_m, drv, head}, {dh[6], dh[4], dh[3:0]});
         for (k = 2; k < 6; k = k + 1) begin
            rd(1'b0, k[2:0], 2'b10);
            chk({q[7:0], oe}, {v[k-2], 16'h00FF});
         end
         rd(1'b1, 3'h7, 2'b10);
         chk({q & 16'h007F, oe}, {da(dh, drive_id, busy), 16'h007F});
      end
      wr(1'b0, 3'h0, 2'b01, 16'hC35A);
      chk({feat, mw_valid}, {8'hC3, 1'b0});
      wr(1'b0, 3'h1, 2'b10, 16'hFF96);
      chk(feat, 8'h96);
      err_bits = 8'hA5;
      rd(1'b0, 3'h0, 2'b01);
      chk({q[15:8], oe}, {8'hA5, 16'hFF00});
      rd(1'b0, 3'h1, 2'b10);
      chk({q[7:0], oe}, {8'hA5, 16'h00FF});
      ignore = 1'b1;
      rd(1'b1, 3'h7, 2'b10);
      chk(oe, 16'h0000);
      ignore = 1'b0;
      rd(1'b0, 3'h7, 2'b10);
      chk(oe, 16'h0000);
      wr(1'b0, 3'h2, 2'b10, 16'h0003);
      eng(1'b1, 1'b0, 1'b0);
      chk(cnt, 8'h02);
      eng(1'b0, 1'b1, 1'b0);
      chk(cnt, 8'h02);
      eng(1'b0, 1'b1, 1'b1);
      chk(cnt, 8'h00);
      for (i = 0; i < 16; i = i + 1) begin
         @(negedge clk_sys_i);
         chk(mr_ready, 1'b1);
         w[i] = $random(seed);
         mr_data = w[i];
         mr_valid = 1'b1;
      end
      @(negedge clk_sys_i);
      mr_data = 16'hDEAD;
      repeat (3) @(negedge clk_sys_i);
      chk(mr_ready, 1'b0);
      mr_valid = 1'b0;
      for (i = 0; i < 16; i = i + 1) begin
         rd(1'b0, 3'h0, (i == 0) ? 2'b10 : 2'b00);
         chk({q & oe, oe}, (i == 0) ? {8'h00, w[0][7:0], 16'h00FF} : {w[i], 16'hFFFF});
      end
      rd(1'b0, 3'h0, 2'b00);
      chk({q, oe}, {16'h0000, 16'hFFFF});
      d = $random(seed);
      mw(2'b00, d, d);
      mw(2'b10, 16'hABCD, 16'h00CD);
      finish_test;
   end
endmodule

// *** atf_task_file_sva.sv ***
// Checker of the task-file bank behaviour seen at its ports
`timescale 1ns/1ps
module atf_task_file_sva (
   input wire clk_sys_i,
   input wire rst_i,
   input wire [15:0] data_o,
   input wire [15:0] data_oe_o,
   input wire drive_id_i,
   input wire ignore_drive_addr_i,
   input wire write_busy_i,
   input wire sector_done_i,
   input wire cmd_done_i,
   input wire cmd_ok_i,
   input wire media_wr_valid_o,
   input wire media_wr_ready_i,
   input wire [7:0] transfer_sector_count_o,
   input wire [8:0] sectors_requested_o,
   input wire [27:0] logical_block_address_o,
   input wire [3:0] head_select_bits_o,
   input wire drive_bit_o
);
   // Readback lanes are being driven
   wire rb = (data_oe_o == 16'h007F);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   a_write_flag_low: assert property (rb |-> data_o[6] == !$past(write_busy_i))
      else $error("write flag bit wrong");
   a_head_inverted: assert property (rb |-> data_o[5:2] == ~head_select_bits_o)
      else $error("inverted head bits wrong");
   a_drive_one_bit: assert property (rb |-> data_o[1] == !(drive_bit_o && drive_id_i))
      else $error("drive one bit wrong");
   a_drive_zero_bit: assert property (rb |-> data_o[0] == (drive_bit_o || drive_id_i))
      else $error("drive zero bit wrong");
   a_lane_enables: assert property (data_oe_o inside {16'h0000, 16'h00FF, 16'hFF00,
      16'hFFFF, 16'h007F}) else $error("illegal lane enable pattern");
   a_ignore_readback: assert property (ignore_drive_addr_i && $past(ignore_drive_addr_i, 4)
      |-> !rb) else $error("readback answered while ignored");
   a_count_cleared: assert property (cmd_done_i && cmd_ok_i |=> transfer_sector_count_o == 8'h00)
      else $error("count not cleared on success");
   a_count_kept: assert property (cmd_done_i && !cmd_ok_i && !sector_done_i
      |=> $stable(transfer_sector_count_o)) else $error("count changed on failure");
   a_count_step_down: assert property (sector_done_i && !cmd_done_i
      && transfer_sector_count_o != 8'h00
      |=> transfer_sector_count_o == $past(transfer_sector_count_o) - 8'h01)
      else $error("count not decremented");
   a_zero_full_request: assert property (transfer_sector_count_o == 8'h00
      |-> sectors_requested_o == 9'h100) else $error("zero count not 256");
   a_lba_top_nibble: assert property ($stable(head_select_bits_o)
      |-> logical_block_address_o[27:24] == head_select_bits_o) else $error("lba top wrong");
   a_media_hold: assert property (media_wr_valid_o && !media_wr_ready_i |=> media_wr_valid_o)
      else $error("media word dropped");
   // Main scenarios reached
   c_readback: cover property (rb);
   c_word_read: cover property (data_oe_o == 16'hFFFF);
   c_full_request: cover property (sectors_requested_o == 9'h100);
endmodule
bind atf_task_file atf_task_file_sva u_sva (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
   .data_o(data_o), .data_oe_o(data_oe_o), .drive_id_i(drive_id_i),
   .ignore_drive_addr_i(ignore_drive_addr_i), .write_busy_i(write_busy_i),
   .sector_done_i(sector_done_i), .cmd_done_i(cmd_done_i), .cmd_ok_i(cmd_ok_i),
   .media_wr_valid_o(media_wr_valid_o), .media_wr_ready_i(media_wr_ready_i),
   .transfer_sector_count_o(transfer_sector_count_o),
   .sectors_requested_o(sectors_requested_o),
   .logical_block_address_o(logical_block_address_o),
   .head_select_bits_o(head_select_bits_o), .drive_bit_o(drive_bit_o));
